// ### design/blt_boot_timer.v
/*
  Boot-load watchdog / general millisecond timer with boot progress counters, behind an AXI4-Lite slave.
  Assumes the boot sequencer drives its status and event pulses synchronous to mclk, one cycle each.
*/
`include "blt_timer_map.vh"

module blt_boot_timer #(
  parameter ADDR_W = 20,
  parameter TICK_CYCLES = `BLT_TICK_CYCLES
) (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // boot sequencer status and events
  input wire bootActive,
  input wire bootDone,
  input wire entryCountLoad,
  input wire [15:0] entryCountValue,
  input wire pairRead,
  input wire chainLoad,
  input wire [15:0] chainAddr,
  input wire paddrIncrement,
  // expiry events, one-cycle pulses
  output reg bootTimeoutEvent,
  output reg generalTimerExpiredEvent
);

  // timer state
  reg [15:0] periodCount_reg;
  reg autoReloadEnable_reg;
  reg [15:0] remaining_reg;
  reg running_reg;
  reg [31:0] divCount_reg;
  reg msTick_reg;
  // progress state
  reg [15:0] remainingEntryCount_reg;
  reg [15:0] paddr_reg;
  // write channel holding
  reg awHeld_reg;
  reg [ADDR_W-1:0] awAddr_reg;
  reg wHeld_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;

  wire writeFire;
  wire timerWrite;
  wire [15:0] newCount;
  wire newAutoReload;
  wire expire;
  wire [32:0] readAnswer;
  wire [32:0] writeDecode;

  // byte-lane merge, used for the two count lanes; the flag lane takes strobe 3 directly
  function [7:0] laneMerge;
    input [7:0] oldByte;
    input [7:0] newByte;
    input strobe;
    begin
      laneMerge = strobe ? newByte : oldByte;
    end
  endfunction

  // read mux, also the address decode for unmapped answers
  function [32:0] readWord;
    input [ADDR_W-1:0] addr;
    input [15:0] cnt;
    input ar;
    input [15:0] entries;
    input [15:0] paddr;
    begin
      readWord = 33'h0_0000_0000;
      if (addr == `BLT_TIMER_OFFSET) begin
        readWord[32] = 1'b1;
        readWord[`BLT_AUTO_RELOAD_BIT] = ar; // reserved bits stay zero
        readWord[`BLT_COUNT_MSB:`BLT_COUNT_LSB] = cnt;
      end else if (addr == `BLT_PROGRESS_OFFSET) begin
        readWord[32] = 1'b1;
        readWord[`BLT_ENTRY_MSB:`BLT_ENTRY_LSB] = entries;
        readWord[`BLT_PADDR_MSB:`BLT_PADDR_LSB] = paddr;
      end
    end
  endfunction

  // a write completes once both address and data are held
  assign writeFire = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign timerWrite = writeFire && (awAddr_reg == `BLT_TIMER_OFFSET);
  assign newCount = {laneMerge(periodCount_reg[15:8], wData_reg[15:8], wStrb_reg[1]),
                     laneMerge(periodCount_reg[7:0], wData_reg[7:0], wStrb_reg[0])};
  assign newAutoReload = wStrb_reg[3] ? wData_reg[`BLT_AUTO_RELOAD_BIT] : autoReloadEnable_reg;
  // decoded answers; bit 32 marks a mapped register, the rest is the read word
  assign readAnswer = readWord(s_axi_araddr, periodCount_reg, autoReloadEnable_reg,
                               remainingEntryCount_reg, paddr_reg);
  assign writeDecode = readWord(awAddr_reg, 16'h0000, 1'b0, 16'h0000, 16'h0000);
  // last millisecond of a live run
  assign expire = running_reg && msTick_reg && (remaining_reg == 16'h0001);

  // write address and data are taken in either order and held
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= {ADDR_W{1'b0}};
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (writeFire) begin
        awHeld_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (writeFire) begin
        wHeld_reg <= 1'b0;
      end
      // ready only while the holding slot is free and no response is pending, and low from the cycle after a take
      s_axi_awready <= !awHeld_reg && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld_reg && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // write response; writes to the progress register are accepted but change nothing
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BLT_RESP_OKAY;
    end else if (writeFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= writeDecode[32] ? `BLT_RESP_OKAY : `BLT_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one read at a time, data captured at the address handshake
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BLT_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readAnswer[31:0];
        s_axi_rresp <= readAnswer[32] ? `BLT_RESP_OKAY : `BLT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // millisecond tick divider; restarted with the timer so each run gets full milliseconds
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      divCount_reg <= 32'h0000_0000;
      msTick_reg <= 1'b0;
    end else if (timerWrite) begin
      divCount_reg <= 32'h0000_0000;
      msTick_reg <= 1'b0;
    end else if (divCount_reg == TICK_CYCLES - 1) begin
      divCount_reg <= 32'h0000_0000;
      msTick_reg <= 1'b1;
    end else begin
      divCount_reg <= divCount_reg + 32'h0000_0001;
      msTick_reg <= 1'b0;
    end
  end

  // timer core: software write wins over boot completion in the same cycle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      periodCount_reg <= `BLT_COUNT_RESET;
      autoReloadEnable_reg <= 1'b0;
      remaining_reg <= `BLT_COUNT_RESET;
      running_reg <= 1'b1; // boot watchdog runs from reset
    end else if (timerWrite) begin
      periodCount_reg <= newCount;
      autoReloadEnable_reg <= newAutoReload;
      remaining_reg <= newCount;
      running_reg <= (newCount != 16'h0000);
    end else if (bootDone) begin
      periodCount_reg <= 16'h0000;
      remaining_reg <= 16'h0000;
      running_reg <= 1'b0;
    end else if (expire) begin
      if (autoReloadEnable_reg) begin
        remaining_reg <= periodCount_reg;
      end else begin
        running_reg <= 1'b0;
        remaining_reg <= 16'h0000;
      end
    end else if (running_reg && msTick_reg) begin
      remaining_reg <= remaining_reg - 16'h0001;
    end
  end

  // expiry events; a restarting write suppresses the old run's event
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bootTimeoutEvent <= 1'b0;
      generalTimerExpiredEvent <= 1'b0;
    end else begin
      bootTimeoutEvent <= expire && !timerWrite && !bootDone && bootActive;
      generalTimerExpiredEvent <= expire && !timerWrite && !bootDone && !bootActive;
    end
  end

  // boot progress counters, read-only to software
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      remainingEntryCount_reg <= 16'h0000;
      paddr_reg <= 16'h0000;
    end else begin
      if (entryCountLoad) begin
        remainingEntryCount_reg <= entryCountValue;
      end else if (pairRead && (remainingEntryCount_reg != 16'h0000)) begin
        remainingEntryCount_reg <= remainingEntryCount_reg - 16'h0001;
      end
      if (chainLoad) begin
        paddr_reg <= {chainAddr[15:3], 3'h0};
      end else if (paddrIncrement) begin
        paddr_reg <= paddr_reg + 16'h0001;
      end
    end
  end

endmodule // blt_boot_timer

// ### design/blt_timer_map.vh
/*
  Register map, field positions, reset values and timing constants for the boot-load timer and progress block.
  Assumes a 40 MHz system clock and AXI4-Lite byte addressing.
*/
// Behaviour
// - timer length is a 16-bit count times the millisecond tick period.
// - a count of zero disables the timer; no expiry ever fires.
// - any write of a nonzero count to the timer register starts the timer counting.
// - writing while running restarts with the new count; old run gives no event.
// - expiry gives the boot timeout event while booting, else the general event.
// - auto-reload set restarts on expiry with same count; clear stops the timer.
// - after reset the count is 0x0FA0, a four-second boot timeout.
// - boot load finishing before expiry clears the count, disabling the timer.
// - remaining-entry count is read-only, loaded from the first two EEPROM bytes.
// - after a chain operation the remaining-entry count reloads from the new EEPROM.
// - each address/data pair read during boot load decrements the remaining count.
// - read-only peripheral address, zero at reset, increases as boot load reads.
// - a chain loads the peripheral address from the new address, low three bits zero.
`ifndef BLT_TIMER_MAP_VH
`define BLT_TIMER_MAP_VH

// register byte addresses
`define BLT_TIMER_OFFSET 20'h1D35C
`define BLT_PROGRESS_OFFSET 20'h1D3B8

// timer register fields
`define BLT_AUTO_RELOAD_BIT 31
`define BLT_COUNT_MSB 15
`define BLT_COUNT_LSB 0
`define BLT_COUNT_RESET 16'h0FA0

// progress register fields
`define BLT_ENTRY_MSB 31
`define BLT_ENTRY_LSB 16
`define BLT_PADDR_MSB 15
`define BLT_PADDR_LSB 0

// timing: millisecond tick at the 40 MHz clock
`define BLT_TICK_PERIOD_NS 1000000
`define BLT_CLK_PERIOD_NS 25
`define BLT_TICK_CYCLES (`BLT_TICK_PERIOD_NS / `BLT_CLK_PERIOD_NS)

// AXI responses
`define BLT_RESP_OKAY 2'h0
`define BLT_RESP_SLVERR 2'h2

`endif

// ### test/blt_timer_monitor.sv
/*
  checker on the boot timer ports: bus handshakes and expiry events.
  assumes one mclk domain and arst_n asynchronous, active low.
*/
module blt_timer_monitor #(
  parameter TICK_CYCLES = 4
) (
  // clock and reset
  input logic mclk,
  input logic arst_n,
  // bus handshakes
  input logic s_axi_awready,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // boot status and events
  input logic bootActive,
  input logic bootTimeoutEvent,
  input logic generalTimerExpiredEvent
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // cycles since the last event, saturating so it never wraps on long idle spans
  int sinceEvt_reg;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sinceEvt_reg <= 0;
    end else if (bootTimeoutEvent || generalTimerExpiredEvent) begin
      sinceEvt_reg <= 0;
    end else if (sinceEvt_reg < 1000) begin
      sinceEvt_reg <= sinceEvt_reg + 1;
    end
  end
  // one timer cannot expire twice within one millisecond tick
  evt_gap_a: assert property ((bootTimeoutEvent || generalTimerExpiredEvent) |-> sinceEvt_reg >= TICK_CYCLES - 1)
    else $error("events closer than one tick");
  // only one event kind per expiry, chosen by boot state one cycle before
  evt_excl_a: assert property (!(bootTimeoutEvent && generalTimerExpiredEvent))
    else $error("both events at once");
  boot_sel_a: assert property (bootTimeoutEvent |-> $past(bootActive))
    else $error("boot event while idle");
  gen_sel_a: assert property (generalTimerExpiredEvent |-> !$past(bootActive))
    else $error("general event while booting");
  evt_pulse_a: assert property ($rose(bootTimeoutEvent | generalTimerExpiredEvent)
    |=> !(bootTimeoutEvent | generalTimerExpiredEvent)) else $error("event longer than one cycle");
  // the cycle a write response rises and the three cycles after it carry no event
  wr_quiet_a: assert property ($rose(s_axi_bvalid)
    |-> !(bootTimeoutEvent | generalTimerExpiredEvent) [*4]) else $error("event right after write");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // blt_timer_monitor

bind blt_boot_timer blt_timer_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_blt_timer_monitor (.mclk, .arst_n,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .bootActive, .bootTimeoutEvent, .generalTimerExpiredEvent);

// ### test/blt_boot_seq_model.sv
/*
  stand-in for the boot sequencer: status level and one-cycle strobes.
  assumes the bench calls its tasks and mclk is the block's clock.
*/
module blt_boot_seq_model (
  // clock
  input logic mclk,
  // status and strobes
  output logic bootActive,
  output logic bootDone,
  output logic entryCountLoad,
  output logic [15:0] entryCountValue,
  output logic pairRead,
  output logic chainLoad,
  output logic [15:0] chainAddr,
  output logic paddrIncrement
);
  // idle at time zero
  initial begin
    {bootActive, bootDone, entryCountLoad, pairRead, chainLoad, paddrIncrement} = 6'h00;
    entryCountValue = 16'h0000;
    chainAddr = 16'h0000;
  end
  // boot state is a level, changed just after an edge
  task automatic setActive(input logic a);
    @(posedge mclk);
    bootActive <= a;
  endtask
  // strobe kinds: 0 done, 1 load, 2 pair, 3 chain, 4 increment
  task automatic pulse(input int k, input logic [15:0] v);
    @(posedge mclk);
    case (k)
      0: bootDone <= 1'b1;
      1: begin entryCountLoad <= 1'b1; entryCountValue <= v; end
      2: pairRead <= 1'b1;
      3: begin chainLoad <= 1'b1; chainAddr <= v; end
      default: paddrIncrement <= 1'b1;
    endcase
    @(posedge mclk);
    {bootDone, entryCountLoad, pairRead, chainLoad, paddrIncrement} <= 5'h00;
    // stale values must not look valid once the strobe is gone
    entryCountValue <= ~v;
    chainAddr <= ~v;
  endtask
endmodule // blt_boot_seq_model

// ### test/test_boot_load_timer_progress.sv
/*
  self-checking bench: bus reads and writes, timer runs and boot progress.
  assumes a 4-cycle tick so timer runs stay short.
*/
`include "blt_timer_map.vh"
module test_boot_load_timer_progress;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 4;
  localparam logic [19:0] TMR = `BLT_TIMER_OFFSET;
  localparam logic [19:0] PRG = `BLT_PROGRESS_OFFSET;
  logic mclk = 1'b0, arst_n = 1'b0;
  logic [19:0] s_axi_awaddr = 20'h0, s_axi_araddr = 20'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, e;
  logic bootActive, bootDone, entryCountLoad, pairRead, chainLoad, paddrIncrement;
  logic bootTimeoutEvent, generalTimerExpiredEvent;
  logic [15:0] entryCountValue, chainAddr;
  int failures = 0, comparisons = 0, n;
  // 40 MHz
  always #12.5 mclk = ~mclk;
  blt_boot_timer #(.TICK_CYCLES(T)) u_blt_boot_timer (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .bootActive, .bootDone, .entryCountLoad, .entryCountValue, .pairRead, .chainLoad, .chainAddr,
    .paddrIncrement, .bootTimeoutEvent, .generalTimerExpiredEvent);
  blt_boot_seq_model u_blt_boot_seq_model (.mclk, .bootActive, .bootDone, .entryCountLoad, .entryCountValue,
    .pairRead, .chainLoad, .chainAddr, .paddrIncrement);
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      failures++;
      $display("unexpected at %0t: got %h, want %h", $time, s, x);
    end
  endtask
  // write: both channels offered together, bready held until the answer
  task automatic axiWrite(input logic [19:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (k = 0; k < 40 && !s_axi_bvalid; k++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k == 40) failures++;
  endtask
  task automatic axiRead(input logic [19:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (k = 0; k < 40 && !s_axi_rvalid; k++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    {v, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    if (k == 40) failures++;
  endtask
  // cycles until an event is sampled, counted from the write's answer edge; 201 means none came
  task automatic waitEvt(output int c, output logic [1:0] ev);
    for (c = 1; c <= 200 && !(bootTimeoutEvent | generalTimerExpiredEvent); c++) @(posedge mclk);
    ev = {bootTimeoutEvent, generalTimerExpiredEvent};
  endtask
  task tally_and_finish;
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a hang is cut off well past the expected run
  initial begin
    #(25 * 4000);
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    axiRead(TMR, d, r); check(d, 32'h00000FA0);
    axiRead(PRG, d, r); check(d, 32'h00000000);
    u_blt_boot_seq_model.setActive(1'b1);
    axiWrite(TMR, 32'h00000002, r); waitEvt(n, e); check(32'(n), 2 * T + 2);
    check(32'(e), 32'h2);
    // second write lands mid-run and pushes expiry out
    u_blt_boot_seq_model.setActive(1'b0);
    axiWrite(TMR, 32'h00000003, r);
    repeat (6) @(posedge mclk);
    axiWrite(TMR, 32'h00000003, r); waitEvt(n, e); check(32'(n), 3 * T + 2);
    check(32'(e), 32'h1);
    // let the pulse just seen pass; a one-shot run must then stay quiet
    @(posedge mclk);
    waitEvt(n, e); check(32'(n), 201);
    axiWrite(TMR, 32'h80000001, r); waitEvt(n, e); check(32'(n), T + 2);
    @(posedge mclk);
    waitEvt(n, e); check(32'(n), T);
    axiWrite(TMR, 32'hFFFF0000, r); waitEvt(n, e); check(32'(n), 201);
    axiRead(TMR, d, r); check(d, 32'h80000000);
    axiWrite(TMR, 32'h00000002, r);
    u_blt_boot_seq_model.pulse(0, 16'h0000);
    axiRead(TMR, d, r); check(d, 32'h00000000);
    waitEvt(n, e); check(32'(n), 201);
    u_blt_boot_seq_model.pulse(1, 16'h0005);
    repeat (2) u_blt_boot_seq_model.pulse(2, 16'h0000);
    repeat (3) u_blt_boot_seq_model.pulse(4, 16'h0000);
    axiRead(PRG, d, r); check(d, 32'h00030003);
    u_blt_boot_seq_model.pulse(3, 16'h1237);
    u_blt_boot_seq_model.pulse(1, 16'h0009);
    axiRead(PRG, d, r); check(d, 32'h00091230);
    axiWrite(PRG, 32'hFFFFFFFF, r); check(32'(r), 32'(`BLT_RESP_OKAY));
    axiRead(PRG, d, r); check(d, 32'h00091230);
    axiWrite(20'h00000, 32'h00000001, r); check(32'(r), 32'(`BLT_RESP_SLVERR));
    axiRead(20'h00000, d, r); check(32'(r), 32'(`BLT_RESP_SLVERR));
    tally_and_finish;
  end
endmodule // test_boot_load_timer_progress
